// ### include/fbxc_defines.vh
// constants and register map of the fieldbus buffer exchange control
//
// Functional notes
// - in change mode a new output buffer that differs from the stored copy starts a transmission.
// - in trigger mode a transmission starts only when byte 0 of the unswapped output buffer changes, never otherwise.
// - in trigger mode every received telegram increments the input trigger byte.
// - in trigger mode with swapping off, byte 0 of both input and output buffers is the trigger byte, not user data.
// - a configuration bit selects whether a length byte is kept in the buffers.
// - with the length byte on, the number of bytes held in the output length byte is sent, capped at the end of the buffer.
// - with the length byte on, the count of received characters is written to the input length byte.
// - with swapping on, high and low bytes of every 16 bit word are exchanged in both directions.
// - swapping applies to the whole buffer, not to a region.
`ifndef FBXC_DEFINES_VH
`define FBXC_DEFINES_VH
// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define FBXC_REG_CTRL 4'h0
`define FBXC_REG_STAT 4'h4
`define FBXC_REG_TXCNT 4'h8
`define FBXC_REG_RXCNT 4'hc
// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define FBXC_CTRL_TRIG 0
`define FBXC_CTRL_LEN 1
`define FBXC_CTRL_SWAP 2
`define FBXC_CTRL_RST 3'h0
// ------------------------------------------------------------
// status fields
// ------------------------------------------------------------
`define FBXC_STAT_BUSY 0
`define FBXC_STAT_RXTRIG_LO 8
`define FBXC_STAT_RXTRIG_HI 15
`endif

// ### hdl/fbxc_top.v
// fieldbus buffer exchange control: buffer compare, send/receive framing, swap
`timescale 1ns/1ps
`default_nettype none
`include "fbxc_defines.vh"
module fbxc_top #(
  parameter BUF_BYTES = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst_b,
  // avalon-mm slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // cyclic output buffer from the controller
  input wire fb_out_valid,
  input wire [8*BUF_BYTES-1:0] fb_out_buf,
  // cyclic input buffer towards the controller
  output reg [8*BUF_BYTES-1:0] fb_in_buf,
  // send side stream
  output reg tx_valid,
  output reg [7:0] tx_data,
  output reg tx_last,
  input wire tx_ready,
  // receive side stream
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_last
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;

  reg [2:0] ctrl_r;
  reg [8*BUF_BYTES-1:0] prev_r;
  reg [8*BUF_BYTES-1:0] snap_r;
  reg state_r;
  reg [AW:0] idx_r;
  reg [AW:0] end_r;
  reg [AW:0] rx_pos_r;
  reg [7:0] rx_cnt_r;
  reg [7:0] rx_trig_r;
  reg [15:0] tx_tel_r;
  reg [15:0] rx_tel_r;
  reg [8*BUF_BYTES-1:0] rx_buf_r;

  wire trig_on = ctrl_r[`FBXC_CTRL_TRIG];
  wire len_on = ctrl_r[`FBXC_CTRL_LEN];
  wire swap_on = ctrl_r[`FBXC_CTRL_SWAP];

  // header layout: trigger, then length, then data
  wire [AW:0] hdr = {{AW{1'b0}}, trig_on} + {{AW{1'b0}}, len_on};
  wire [AW:0] len_pos = {{AW{1'b0}}, trig_on};

  // ------------------------------------------------------------
  // swap network
  // ------------------------------------------------------------
  // swap every word of the whole buffer
  wire [8*BUF_BYTES-1:0] out_sw;
  genvar g;
  generate
    for (g = 0; g < BUF_BYTES; g = g + 1) begin : g_sw
      localparam integer P = (g % 2 == 0 && g + 1 < BUF_BYTES) ? g + 1 : ((g % 2 == 1) ? g - 1 : g);
      assign out_sw[8*g +: 8] = fb_out_buf[8*P +: 8];
    end
  endgenerate
  wire [8*BUF_BYTES-1:0] out_eff = swap_on ? out_sw : fb_out_buf;

  function [AW:0] swap_idx;
    input [AW:0] i;
    input sw;
    begin
      if (sw && (i[0] || (i + 1'b1 < BUF_BYTES)))
        swap_idx = {i[AW:1], ~i[0]};
      else
        swap_idx = i;
    end
  endfunction

  // ------------------------------------------------------------
  // send decision
  // ------------------------------------------------------------
  // content compare only in change mode
  wire chg_hit = !trig_on && (fb_out_buf != prev_r);
  wire trg_hit = trig_on && (fb_out_buf[7:0] != prev_r[7:0]);
  wire send_go = fb_out_valid && (state_r == ST_IDLE) && (chg_hit || trg_hit);

  // send length from the output length byte, capped to the buffer
  wire [7:0] len_raw = out_eff[8*len_pos +: 8];
  wire [8:0] len_end = {1'b0, len_raw} + {{(8-AW){1'b0}}, hdr};
  // buffer size at index width, so the end compare needs no part-select of a parameter
  localparam [AW:0] BUF_END = BUF_BYTES;
  wire [AW:0] send_end = !len_on ? BUF_END :
    (len_end > BUF_BYTES) ? BUF_END : len_end[AW:0];

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_r <= {8*BUF_BYTES{1'b0}};
      snap_r <= {8*BUF_BYTES{1'b0}};
      state_r <= ST_IDLE;
      idx_r <= {(AW+1){1'b0}};
      end_r <= {(AW+1){1'b0}};
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
      tx_tel_r <= 16'h0000;
    end else begin
      if (fb_out_valid && state_r == ST_IDLE)
        prev_r <= fb_out_buf;
      case (state_r)
        ST_IDLE: begin
          if (send_go && send_end > hdr) begin
            snap_r <= out_eff;
            end_r <= send_end;
            idx_r <= hdr;
            state_r <= ST_SEND;
            tx_valid <= 1'b1;
            tx_data <= out_eff[8*hdr +: 8];
            tx_last <= (hdr + 1'b1 == send_end);
          end
        end
        ST_SEND: begin
          if (tx_ready) begin
            if (tx_last) begin
              tx_valid <= 1'b0;
              tx_last <= 1'b0;
              state_r <= ST_IDLE;
              tx_tel_r <= tx_tel_r + 16'h0001;
            end else begin
              idx_r <= idx_r + 1'b1;
              tx_data <= snap_r[8*(idx_r + 1'b1) +: 8];
              tx_last <= (idx_r + 2'd2 == end_r);
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // receive path
  // ------------------------------------------------------------
  // position 0 means start of telegram: the first byte lands right after the header
  wire [AW:0] rx_at = (rx_pos_r == {(AW+1){1'b0}}) ? hdr : rx_pos_r;
  wire [AW:0] rx_dst = swap_idx(rx_at, swap_on);
  wire [7:0] rx_cnt_fin = rx_cnt_r + 8'h01;
  wire [7:0] rx_trig_nxt = rx_trig_r + 8'h01;
  wire [AW:0] len_dst = swap_idx(len_pos, swap_on);
  wire [AW:0] trg_dst = swap_idx({(AW+1){1'b0}}, swap_on);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_pos_r <= {(AW+1){1'b0}};
      rx_cnt_r <= 8'h00;
      rx_trig_r <= 8'h00;
      rx_buf_r <= {8*BUF_BYTES{1'b0}};
      fb_in_buf <= {8*BUF_BYTES{1'b0}};
      rx_tel_r <= 16'h0000;
    end else if (rx_valid) begin
      if (rx_at < BUF_BYTES)
        rx_buf_r[8*rx_dst +: 8] <= rx_data;
      if (rx_last) begin
        rx_pos_r <= {(AW+1){1'b0}};
        rx_cnt_r <= 8'h00;
        rx_tel_r <= rx_tel_r + 16'h0001;
        fb_in_buf <= rx_buf_r;
        if (rx_at < BUF_BYTES)
          fb_in_buf[8*rx_dst +: 8] <= rx_data;
        // received character count into the length byte
        if (len_on)
          fb_in_buf[8*len_dst +: 8] <= rx_cnt_fin;
        if (trig_on) begin
          rx_trig_r <= rx_trig_nxt;
          fb_in_buf[8*trg_dst +: 8] <= rx_trig_nxt;
        end
      end else begin
        rx_cnt_r <= rx_cnt_fin;
        rx_pos_r <= rx_at + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // avalon-mm registers
  // ------------------------------------------------------------
  // length byte select held in the control register
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= `FBXC_CTRL_RST;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= 1'b1;
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        if (avs_write && avs_address == `FBXC_REG_CTRL)
          ctrl_r <= avs_writedata[2:0];
        if (avs_address == `FBXC_REG_CTRL)
          avs_readdata <= {29'h0, ctrl_r};
        else if (avs_address == `FBXC_REG_STAT)
          avs_readdata <= {16'h0, rx_trig_r, 7'h0, state_r};
        else if (avs_address == `FBXC_REG_TXCNT)
          avs_readdata <= {16'h0, tx_tel_r};
        else if (avs_address == `FBXC_REG_RXCNT)
          avs_readdata <= {16'h0, rx_tel_r};
        else
          avs_readdata <= 32'h00000000;
      end
      if (!avs_waitrequest)
        avs_waitrequest <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### testbench/fbxc_plc_model.sv
// cyclic fieldbus controller model
`timescale 1ns/1ps
`default_nettype none
module fbxc_plc_model #(
  parameter BUF_BYTES = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [8*BUF_BYTES-1:0] next_buf,
  output logic fb_out_valid,
  output logic [8*BUF_BYTES-1:0] fb_out_buf
);
  // ----
  // cyclic exchange
  // ----
  logic [2:0] cyc_r;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_r <= 3'h0;
      fb_out_valid <= 1'b0;
      fb_out_buf <= '0;
    end else begin
      cyc_r <= cyc_r + 3'h1;
      fb_out_valid <= (cyc_r == 3'h7);
      // garbage between pulses so a stale sample cannot pass
      fb_out_buf <= (cyc_r == 3'h7) ? next_buf : ~next_buf;
    end
  end
endmodule
`default_nettype wire

// ### testbench/fbxc_top_props.sv
// port checks of the buffer exchange control
`timescale 1ns/1ps
`default_nettype none
module fbxc_top_props #(
  parameter BUF_BYTES = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic fb_out_valid,
  input wire logic [8*BUF_BYTES-1:0] fb_in_buf,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic rx_last
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("send byte not held");
  AST_TX_END: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
    else $error("send runs past last");
  AST_TX_LAST: assert property (tx_last |-> tx_valid)
    else $error("last without valid");
  AST_TX_STOP: assert property ($fell(tx_valid) |-> $past(tx_ready && tx_last))
    else $error("send cut short");
  AST_TX_START: assert property ($rose(tx_valid) |-> $past(fb_out_valid))
    else $error("send without buffer");
  AST_WAIT_ANS: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer too long");
  AST_IN_UPD: assert property ($changed(fb_in_buf) |-> $past(rx_valid && rx_last) || $past(rx_valid && rx_last, 2))
    else $error("input buffer moved");
endmodule
bind fbxc_top fbxc_top_props #(.BUF_BYTES(BUF_BYTES)) fbxc_top_props_inst (.clk, .rst_b, .avs_read, .avs_write,
  .avs_waitrequest, .fb_out_valid, .fb_in_buf, .tx_valid, .tx_data, .tx_last, .tx_ready, .rx_valid, .rx_last);
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench of the buffer exchange control
`timescale 1ns/1ps
`default_nettype none
`include "fbxc_defines.vh"
module testbench;
  localparam logic [127:0] B = 128'h0f0e0d0c0b0a09080706050403020100;
  localparam logic [127:0] T1 = 128'h00000000000000000000004433220301;
  localparam logic [127:0] X = 128'h00000000000000000000000000ff0000;
  logic clk, rst_b, rd, wr, wreq, fbv, txv, txl, txr, rxv, rxl;
  logic [3:0] adr;
  logic [7:0] txd, rxd;
  logic [31:0] wdat, rdat, r;
  logic [127:0] fbb, nbuf, ibuf;
  logic [7:0] q[$];
  int fail_count, compares;
  fbxc_top fbxc_top_inst (.clk(clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq), .fb_out_valid(fbv), .fb_out_buf(fbb),
    .fb_in_buf(ibuf), .tx_valid(txv), .tx_data(txd), .tx_last(txl), .tx_ready(txr), .rx_valid(rxv),
    .rx_data(rxd), .rx_last(rxl));
  fbxc_plc_model fbxc_plc_model_inst (.clk(clk), .rst_b(rst_b), .next_buf(nbuf), .fb_out_valid(fbv),
    .fb_out_buf(fbb));
  // ----
  // clock, stall, capture
  // ----
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // stalling every other cycle forces the sender to hold bytes
  always @(posedge clk) txr <= ~txr;
  always @(posedge clk) if (txv && txr) q.push_back(txd);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (wreq) @(posedge clk);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic send(input logic [127:0] b, input int n, input int f, input int s);
    @(posedge clk);
    q = {};
    nbuf <= b;
    repeat (70) @(posedge clk);
    chk(q.size(), n);
    foreach (q[k]) chk(q[k], b[8*((f+k)^s) +: 8]);
  endtask
  task automatic rxs(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      rxv <= 1'b1;
      rxd <= 8'ha0 + 8'(k);
      rxl <= (k == n - 1);
    end
    @(posedge clk);
    rxv <= 1'b0;
    rxl <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic end_sim;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    {rd, wr, txr, rxv, rxl, rst_b, adr, wdat, rxd, nbuf} = '0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b1, `FBXC_REG_CTRL, 32'h0);
    send(B, 16, 0, 0);
    send(B, 0, 0, 0);
    bus(1'b1, `FBXC_REG_CTRL, 32'h4);
    send(~B, 16, 0, 1);
    bus(1'b1, `FBXC_REG_CTRL, 32'h3);
    bus(1'b0, `FBXC_REG_CTRL, 32'h0);
    chk(r, 32'h3);
    send(T1, 3, 2, 0);
    send(T1 ^ X, 0, 2, 0);
    send(T1 ^ X ^ 128'h1, 3, 2, 0);
    rxs(2);
    chk(ibuf[31:0], 32'ha1a00201);
    bus(1'b0, `FBXC_REG_STAT, 32'h0);
    chk(r[15:8], 32'h1);
    bus(1'b0, 4'h2, 32'h0);
    chk(r, 32'h0);
    end_sim;
  end
  // about ten times the expected run
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_sim;
  end
endmodule
`default_nettype wire
